// file: hdl/hmc_pkg.sv
// Shared constants and types for the second host mailbox channel
package hmc_pkg;
   localparam int unsigned DATA_W            = 8;
   localparam int unsigned FIFO_DEPTH        = 16;
   localparam int unsigned QUEUE_W           = DATA_W + 1;
   localparam int unsigned SEL_W             = 3;

   // Slave-side register select codes
   localparam logic [2:0]  SEL_INPUT         = 3'h0;
   localparam logic [2:0]  SEL_OUTPUT        = 3'h1;
   localparam logic [2:0]  SEL_STATUS        = 3'h2;
   localparam logic [2:0]  SEL_SHARED_CTRL   = 3'h3;
   localparam logic [2:0]  SEL_PORT_CTRL     = 3'h4;
   localparam logic [2:0]  SEL_SYS_CTRL      = 3'h5;

   // Status byte layout
   localparam int unsigned ST_CMD_BIT        = 3;
   localparam int unsigned ST_IBF_BIT        = 1;
   localparam int unsigned ST_OBF_BIT        = 0;
   localparam logic [7:0]  ST_SPARE_MASK     = 8'hF4;
   localparam logic [7:0]  STATUS_RESET      = 8'h00;

   // Shared serial/timer control
   localparam logic [7:0]  SHARED_RESET      = 8'h00;
   localparam int unsigned SHARED_PINSEL_BIT = 3;

   // Host port control: upper bits fixed at one
   localparam logic [7:0]  PORTCTRL_RESET    = 8'hF8;
   localparam logic [7:0]  PORTCTRL_WMASK    = 8'h07;
   localparam int unsigned PORTCTRL_IEN_BIT  = 2;

   // System control: only the port enable is kept here
   localparam logic [7:0]  SYSCTRL_RESET     = 8'h00;
   localparam int unsigned SYSCTRL_HIE_BIT   = 1;

   // Idle level of {select, write, read, address} after synchronising
   localparam logic [3:0]  PIN_IDLE          = 4'hE;

   typedef enum logic [1:0] {
      HS_IDLE,
      HS_WRITE,
      HS_READ
   } hmc_host_state_t;
endpackage

// file: hdl/hmc_sync.sv
// Two-flop synchroniser for host pins
`timescale 1ns/1ps
module hmc_sync #(
   parameter int unsigned W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // hmc_sync

// file: hdl/hmc_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module hmc_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   logic             full;
   logic             empty;

   // Extra pointer bit tells full from empty
   assign empty    = (wrPtr_r == rdPtr_r);
   assign full     = (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]) && (wrPtr_r[AW] != rdPtr_r[AW]);
   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = mem[rdPtr_r[AW-1:0]];

   always_ff @(posedge clk_sys) begin
      if (inValid && !full) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else if (flush) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (inValid && !full) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (outReady && !empty) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule // hmc_fifo

// file: hdl/hmc_channel_two.sv
// Second channel of the host mailbox port, slave-side registers and host pins
//
// Overview of operation
// - With select low, host write strobe rising edge captures the host data bus.
// - Each host write latches the address bit into status bit 3; one means command. Here it loads as the word leaves the queue; dropped words never load.
// - Output byte drives host bus only with address low, select low, read low.
// - Input byte: host writes only, slave reads only; slave writes ignored.
// - Output byte: slave reads and writes; host only reads; host writes never alter it.
// - Input and output bytes have no reset value.
// - Status byte clears to zero on reset and during hardware standby.
// - Status bits 3, 1, 0 are read-only; slave writes there are ignored.
// - Status bits 7 to 4 and 2 are spare, slave read/write, host read.
// - Input-full flag, status bit 1, sets on host write strobe rising edge. Here it sets when a queued word loads the input byte.
// - Input-full clears on falling edge of slave read of the input byte.
// - Input-full flag is an interrupt source to the slave processor.
// - Input-full interrupt reaches the slave only when port control bit 2 is one.
// - Output-full flag, status bit 0, sets on falling edge of slave write.
// - Output-full clears on host read strobe rising edge when reading output byte.
// - Host read: address zero returns output byte, address one returns status.
// - Shared control register resets to zero on reset and standby; all bits read/write.
// - Pin source select bit 3 picks primary or alternate select and write pins.
// - Pin source select acts only while the host port is enabled.
// - Host port answers transfers only when system control bit 1 is one.
`timescale 1ns/1ps
module hmc_channel_two (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       hwStandby_b,
   input  wire logic       hostSelectTwo_b,
   input  wire logic       hostWriteStrobe_b,
   input  wire logic       altHostSelectTwo_b,
   input  wire logic       altHostWriteStrobe_b,
   input  wire logic       hostReadStrobe_b,
   input  wire logic       hostAddressBit,
   input  wire logic [7:0] hostDataIn,
   output logic      [7:0] hostDataOut,
   output logic            hostDataOe_b,
   output logic            hostQueueReady,
   input  wire logic [2:0] slvSel,
   input  wire logic       slvRd,
   input  wire logic       slvWr,
   input  wire logic [7:0] slvWdata,
   output logic      [7:0] slvRdata,
   output logic            inputFullIrqTwo
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // Registers and flags
   logic [7:0]                inByte_r;
   logic [7:0]                outByte_r;
   logic                      cmdFlag_r;
   logic                      ibf_r;
   logic                      obf_r;
   logic [7:0]                spare_r;
   logic [7:0]                shared_r;
   logic [7:0]                portCtrl_r;
   logic [7:0]                sysCtrl_r;
   logic [7:0]                statusByte;

   // Host side
   logic                      hostEn;
   logic                      pinSel;
   logic [3:0]                pinRaw;
   logic [3:0]                pinSync;
   logic                      selS;
   logic                      wrS;
   logic                      rdS;
   logic                      addrS;
   logic [7:0]                dataS;
   hmc_pkg::hmc_host_state_t  hostState_r;
   hmc_pkg::hmc_host_state_t  hostState_nxt;
   logic                      writeEdge;
   logic                      readEdge;
   logic                      readOutEdge;
   logic                      driveBus;
   logic [7:0]                hostDataOut_r;
   logic                      hostDataOe_b_r;
   logic                      hostQueueReady_r;

   // Queue between host capture and the input byte
   logic                      qInReady;
   logic                      qOutValid;
   logic                      qOutReady;
   logic [8:0]                qOutData;
   logic                      pop;

   // Slave side
   logic                      slvRdPrev_r;
   logic                      slvWrPrev_r;
   logic                      outSeen_r;     // Output byte undefined until first slave write
   logic [2:0]                slvSelPrev_r;
   logic                      rdFallInput;
   logic                      wrFallOutput;
   logic                      slvWrStatus;
   logic                      slvWrOutput;
   logic [7:0]                slvRdata_r;
   logic                      irq_r;

   function automatic logic pinMux(input logic useAlt, input logic prim, input logic alt);
      return useAlt ? alt : prim;
   endfunction

   // Pin source select only matters with the port enabled
   assign hostEn = sysCtrl_r[hmc_pkg::SYSCTRL_HIE_BIT];
   assign pinSel = hostEn && shared_r[hmc_pkg::SHARED_PINSEL_BIT];
   assign pinRaw = {pinMux(pinSel, hostSelectTwo_b, altHostSelectTwo_b),
                    pinMux(pinSel, hostWriteStrobe_b, altHostWriteStrobe_b),
                    hostReadStrobe_b,
                    hostAddressBit};

   // Data takes the same two-cycle path so it lines up with the strobe edge
   hmc_sync #(.W(4), .INIT(hmc_pkg::PIN_IDLE)) u_pinSync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .d       (pinRaw),
      .q       (pinSync)
   );

   hmc_sync #(.W(8), .INIT(8'h00)) u_dataSync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .d       (hostDataIn),
      .q       (dataS)
   );

   assign selS  = pinSync[3];
   assign wrS   = pinSync[2];
   assign rdS   = pinSync[1];
   assign addrS = pinSync[0];

   // Host access tracker: one edge per access
   always_comb begin
      hostState_nxt = hostState_r;
      case (hostState_r)
         hmc_pkg::HS_IDLE: begin
            if (hostEn && !selS && !wrS && rdS) begin
               hostState_nxt = hmc_pkg::HS_WRITE;
            end else if (hostEn && !selS && !rdS && wrS) begin
               hostState_nxt = hmc_pkg::HS_READ;
            end
         end
         hmc_pkg::HS_WRITE: begin
            if (wrS || !hostEn) begin
               hostState_nxt = hmc_pkg::HS_IDLE;
            end
         end
         hmc_pkg::HS_READ: begin
            if (rdS || !hostEn) begin
               hostState_nxt = hmc_pkg::HS_IDLE;
            end
         end
         default: hostState_nxt = hmc_pkg::HS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hostState_r <= hmc_pkg::HS_IDLE;
      end else if (!hwStandby_b) begin
         hostState_r <= hmc_pkg::HS_IDLE;
      end else begin
         hostState_r <= hostState_nxt;
      end
   end

   assign writeEdge   = hostEn && (hostState_r == hmc_pkg::HS_WRITE) && wrS;
   assign readEdge    = hostEn && (hostState_r == hmc_pkg::HS_READ) && rdS;
   assign readOutEdge = readEdge && !addrS;
   assign driveBus    = hostEn && !selS && !rdS && wrS;

   // Host writes are queued; a full queue drops the word and shows on the ready pin
   hmc_fifo #(.WIDTH(hmc_pkg::QUEUE_W), .DEPTH(hmc_pkg::FIFO_DEPTH)) u_queue (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .flush    (!hwStandby_b),
      .inValid  (writeEdge),
      .inReady  (qInReady),
      .inData   ({addrS, dataS}),
      .outValid (qOutValid),
      .outReady (qOutReady),
      .outData  (qOutData)
   );

   // Refill the input byte only once emptied, and never while the slave reads it
   assign qOutReady = !ibf_r && !(slvRd && (slvSel == hmc_pkg::SEL_INPUT));
   assign pop       = qOutValid && qOutReady;

   assign statusByte = (spare_r & hmc_pkg::ST_SPARE_MASK)
                     | ({7'h00, cmdFlag_r} << hmc_pkg::ST_CMD_BIT)
                     | ({7'h00, ibf_r} << hmc_pkg::ST_IBF_BIT)
                     | ({7'h00, obf_r} << hmc_pkg::ST_OBF_BIT);

   // Host bus outputs
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hostDataOut_r    <= 8'h00;
         hostDataOe_b_r   <= 1'b1;
         hostQueueReady_r <= 1'b0;
      end else begin
         hostDataOut_r    <= addrS ? statusByte : outByte_r;
         hostDataOe_b_r   <= !driveBus;
         hostQueueReady_r <= qInReady && hwStandby_b;
      end
   end

   // Slave strobe history for falling-edge detection
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         slvRdPrev_r  <= 1'b0;
         slvWrPrev_r  <= 1'b0;
         slvSelPrev_r <= hmc_pkg::SEL_INPUT;
         outSeen_r    <= 1'b0;
      end else begin
         slvRdPrev_r  <= slvRd;
         slvWrPrev_r  <= slvWr;
         slvSelPrev_r <= slvSel;
         outSeen_r    <= outSeen_r || slvWrOutput;
      end
   end

   assign rdFallInput  = slvRdPrev_r && !slvRd && (slvSelPrev_r == hmc_pkg::SEL_INPUT);
   assign wrFallOutput = slvWrPrev_r && !slvWr && (slvSelPrev_r == hmc_pkg::SEL_OUTPUT);
   assign slvWrStatus  = slvWr && (slvSel == hmc_pkg::SEL_STATUS);
   assign slvWrOutput  = slvWr && (slvSel == hmc_pkg::SEL_OUTPUT);

   // Data bytes carry no reset; software must not trust them before a write
   always_ff @(posedge clk_sys) begin
      if (pop) begin
         inByte_r <= qOutData[7:0];
      end
      if (slvWrOutput) begin
         outByte_r <= slvWdata;
      end
   end

   // Command/data flag and input-full; a new word beats a clearing read
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cmdFlag_r <= 1'b0;
         ibf_r     <= 1'b0;
      end else if (!hwStandby_b) begin
         cmdFlag_r <= 1'b0;
         ibf_r     <= 1'b0;
      end else if (pop) begin
         cmdFlag_r <= qOutData[8];
         ibf_r     <= 1'b1;
      end else if (rdFallInput) begin
         ibf_r     <= 1'b0;
      end
   end

   // Output-full: slave write end sets, host read end clears, set wins
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         obf_r <= 1'b0;
      end else if (!hwStandby_b) begin
         obf_r <= 1'b0;
      end else if (wrFallOutput) begin
         obf_r <= 1'b1;
      end else if (readOutEdge) begin
         obf_r <= 1'b0;
      end
   end

   // Spare status bits; hardware bits are never touched by slave writes
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         spare_r <= hmc_pkg::STATUS_RESET;
      end else if (!hwStandby_b) begin
         spare_r <= hmc_pkg::STATUS_RESET;
      end else if (slvWrStatus) begin
         spare_r <= slvWdata & hmc_pkg::ST_SPARE_MASK;
      end
   end

   // Control registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shared_r   <= hmc_pkg::SHARED_RESET;
         portCtrl_r <= hmc_pkg::PORTCTRL_RESET;
         sysCtrl_r  <= hmc_pkg::SYSCTRL_RESET;
      end else if (!hwStandby_b) begin
         shared_r   <= hmc_pkg::SHARED_RESET;
         portCtrl_r <= hmc_pkg::PORTCTRL_RESET;
         sysCtrl_r  <= hmc_pkg::SYSCTRL_RESET;
      end else if (slvWr) begin
         case (slvSel)
            hmc_pkg::SEL_SHARED_CTRL: shared_r <= slvWdata;
            hmc_pkg::SEL_PORT_CTRL: begin
               portCtrl_r <= (slvWdata & hmc_pkg::PORTCTRL_WMASK)
                           | (hmc_pkg::PORTCTRL_RESET & ~hmc_pkg::PORTCTRL_WMASK);
            end
            hmc_pkg::SEL_SYS_CTRL: begin
               sysCtrl_r <= slvWdata & (8'h01 << hmc_pkg::SYSCTRL_HIE_BIT);
            end
            default: ;
         endcase
      end
   end

   // Slave read data, registered one cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         slvRdata_r <= 8'h00;
      end else if (slvRd) begin
         case (slvSel)
            hmc_pkg::SEL_INPUT:       slvRdata_r <= inByte_r;
            hmc_pkg::SEL_OUTPUT:      slvRdata_r <= outByte_r;
            hmc_pkg::SEL_STATUS:      slvRdata_r <= statusByte;
            hmc_pkg::SEL_SHARED_CTRL: slvRdata_r <= shared_r;
            hmc_pkg::SEL_PORT_CTRL:   slvRdata_r <= portCtrl_r;
            hmc_pkg::SEL_SYS_CTRL:    slvRdata_r <= sysCtrl_r;
            default:                  slvRdata_r <= 8'h00;
         endcase
      end
   end

   // Interrupt to the slave processor
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= ibf_r && portCtrl_r[hmc_pkg::PORTCTRL_IEN_BIT];
      end
   end

   assign hostDataOut     = hostDataOut_r;
   assign hostDataOe_b    = hostDataOe_b_r;
   assign hostQueueReady  = hostQueueReady_r;
   assign slvRdata        = slvRdata_r;
   assign inputFullIrqTwo = irq_r;

   a_host_drive_window: assert property (
      !hostDataOe_b_r |-> $past(hostEn && !selS && !rdS && wrS))
      else $error("host bus driven outside a read access");

   a_host_port_off: assert property (
      !hostEn |=> hostState_r == hmc_pkg::HS_IDLE && hostDataOe_b_r)
      else $error("disabled host port answered a transfer");

   a_cmd_flag_latch: assert property (
      pop && hwStandby_b |=> cmdFlag_r == $past(qOutData[8]))
      else $error("command flag does not follow host address bit");

   a_ibf_set_push: assert property (
      writeEdge && qInReady && !qOutValid && qOutReady && hwStandby_b
      ##1 qOutReady && hwStandby_b |=> ibf_r)
      else $error("input-full not set after host write");

   a_ibf_clear_read: assert property (
      rdFallInput && !pop && hwStandby_b |=> !ibf_r)
      else $error("input-full not cleared by slave read");

   a_obf_set_write: assert property (
      wrFallOutput && hwStandby_b |=> obf_r)
      else $error("output-full not set by slave write");

   a_obf_clear_read: assert property (
      readOutEdge && !wrFallOutput |=> !obf_r)
      else $error("output-full not cleared by host read");

   a_out_byte_hold: assert property (
      outSeen_r && !slvWrOutput |=> $stable(outByte_r))
      else $error("output byte changed without a slave write");

   a_status_standby: assert property (
      !hwStandby_b |=> statusByte == hmc_pkg::STATUS_RESET)
      else $error("status not cleared in standby");

   a_irq_gate: assert property (
      irq_r |-> $past(portCtrl_r[hmc_pkg::PORTCTRL_IEN_BIT] && ibf_r))
      else $error("interrupt raised while disabled");

   a_ro_status_bits: assert property (
      slvWrStatus && !pop && !rdFallInput && !wrFallOutput && !readOutEdge && hwStandby_b
      |=> statusByte[3] == $past(statusByte[3]) && statusByte[1:0] == $past(statusByte[1:0]))
      else $error("slave write altered a read-only status bit");
endmodule // hmc_channel_two

// file: tb/hmc_host.sv
// Host processor model driving the channel two parallel pins
`timescale 1ns/1ps
module hmc_host (
   input  wire logic       clk_sys,
   input  wire logic       useAlt,
   input  wire logic [7:0] hostDataOut,
   input  wire logic       hostDataOe_b,
   output logic            hostSelectTwo_b,
   output logic            hostWriteStrobe_b,
   output logic            altHostSelectTwo_b,
   output logic            altHostWriteStrobe_b,
   output logic            hostReadStrobe_b,
   output logic            hostAddressBit,
   output logic      [7:0] hostDataIn
);
   logic sel_b = 1'b1;
   logic wr_b  = 1'b1;
   // Unused pin pair idles high
   assign hostSelectTwo_b      = sel_b | useAlt;
   assign hostWriteStrobe_b    = wr_b | useAlt;
   assign altHostSelectTwo_b   = sel_b | ~useAlt;
   assign altHostWriteStrobe_b = wr_b | ~useAlt;
   initial begin
      hostReadStrobe_b = 1'b1;
      hostAddressBit   = 1'b0;
      hostDataIn       = 8'h00;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic hostWrite(input logic a, input logic [7:0] d);
      step(1);
      sel_b = 1'b0;
      hostAddressBit = a;
      hostDataIn = d;
      step(1);
      wr_b = 1'b0;
      step(4);
      wr_b = 1'b1;
      step(4);
      sel_b = 1'b1;
      // Released bus must not keep the last byte
      hostDataIn = ~d;
   endtask
   task automatic hostRead(input logic a, output logic [7:0] d, output bit ok);
      step(1);
      sel_b = 1'b0;
      hostAddressBit = a;
      hostReadStrobe_b = 1'b0;
      ok = 1'b0;
      d = 8'h00;
      // Look just after the edge so the registered bus outputs have settled
      for (int n = 0; n < 12 && !ok; n++) begin
         step(1);
         if (hostDataOe_b === 1'b0) begin
            ok = 1'b1;
            d = hostDataOut;
         end
      end
      hostReadStrobe_b = 1'b1;
      step(4);
      sel_b = 1'b1;
   endtask
endmodule // hmc_host

// file: tb/tb_hmc_channel_two.sv
// Self-checking bench for the second host mailbox channel
`timescale 1ns/1ps
module tb_hmc_channel_two;
   logic       clk_sys = 1'b0;
   logic       rst_b = 1'b0;
   logic       hwStandby_b = 1'b1;
   logic       useAlt = 1'b0;
   logic [2:0] slvSel = 3'h0;
   logic       slvRd = 1'b0;
   logic       slvWr = 1'b0;
   logic [7:0] slvWdata = 8'h00;
   logic       hostSelectTwo_b, hostWriteStrobe_b, altHostSelectTwo_b, altHostWriteStrobe_b;
   logic       hostReadStrobe_b, hostAddressBit, hostDataOe_b, hostQueueReady, inputFullIrqTwo;
   logic [7:0] hostDataIn, hostDataOut, slvRdata, rv;
   int         errors = 0;
   int         samples_checked = 0;
   bit         ok;
   always #12.5 clk_sys = ~clk_sys;
   hmc_channel_two hmc_channel_two_inst (
      .clk_sys, .rst_b, .hwStandby_b, .hostSelectTwo_b, .hostWriteStrobe_b, .altHostSelectTwo_b,
      .altHostWriteStrobe_b, .hostReadStrobe_b, .hostAddressBit, .hostDataIn, .hostDataOut,
      .hostDataOe_b, .hostQueueReady, .slvSel, .slvRd, .slvWr, .slvWdata, .slvRdata,
      .inputFullIrqTwo);
   hmc_host hmc_host_inst (
      .clk_sys, .useAlt, .hostDataOut, .hostDataOe_b, .hostSelectTwo_b, .hostWriteStrobe_b,
      .altHostSelectTwo_b, .altHostWriteStrobe_b, .hostReadStrobe_b, .hostAddressBit,
      .hostDataIn);
   task automatic stop_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic sw(input logic [2:0] s, input logic [7:0] d);
      slvSel = s;
      slvWdata = d;
      slvWr = 1'b1;
      tick();
      slvWr = 1'b0;
      tick();
   endtask
   // Mask of zero reads without judging
   task automatic rd(input logic [2:0] s, input logic [7:0] m, input logic [7:0] e);
      slvSel = s;
      slvRd = 1'b1;
      tick();
      slvRd = 1'b0;
      rv = slvRdata;
      tick();
      if (m !== 8'h00) begin
         chk(rv & m, e);
      end
   endtask
   task automatic waitFlag(input int b, input logic e);
      for (int n = 0; n < 20; n++) begin
         rd(hmc_pkg::SEL_STATUS, 8'h00, 8'h00);
         if (rv[b] === e) begin
            samples_checked++;
            return;
         end
      end
      errors++;
      $display("wrong value at %0t: status flag wait ran out", $time);
      stop_test();
   endtask
   task automatic testReset();
      rd(hmc_pkg::SEL_STATUS, 8'hFF, 8'h00);
      rd(hmc_pkg::SEL_SHARED_CTRL, 8'hFF, 8'h00);
      rd(hmc_pkg::SEL_PORT_CTRL, 8'hFF, 8'hF8);
      rd(hmc_pkg::SEL_SYS_CTRL, 8'hFF, 8'h00);
      rd(3'h7, 8'hFF, 8'h00);
      hmc_host_inst.hostWrite(1'b1, 8'h99);
      hmc_host_inst.hostRead(1'b1, rv, ok);
      chk({7'h00, ok}, 8'h00);
      rd(hmc_pkg::SEL_STATUS, 8'hFF, 8'h00);
      sw(hmc_pkg::SEL_SHARED_CTRL, 8'hF7);
      rd(hmc_pkg::SEL_SHARED_CTRL, 8'hFF, 8'hF7);
      sw(hmc_pkg::SEL_SHARED_CTRL, 8'h00);
   endtask
   task automatic testWrite();
      sw(hmc_pkg::SEL_SYS_CTRL, 8'h02);
      hmc_host_inst.hostWrite(1'b1, 8'hA5);
      waitFlag(1, 1'b1);
      chk(rv & 8'h0B, 8'h0A);
      chk({7'h00, inputFullIrqTwo}, 8'h00);
      sw(hmc_pkg::SEL_PORT_CTRL, 8'h04);
      chk({7'h00, inputFullIrqTwo}, 8'h01);
      sw(hmc_pkg::SEL_INPUT, 8'h00);
      rd(hmc_pkg::SEL_INPUT, 8'hFF, 8'hA5);
      waitFlag(1, 1'b0);
      chk({7'h00, inputFullIrqTwo}, 8'h00);
      hmc_host_inst.hostWrite(1'b0, 8'h5A);
      waitFlag(1, 1'b1);
      chk(rv & 8'h08, 8'h00);
      rd(hmc_pkg::SEL_INPUT, 8'hFF, 8'h5A);
      waitFlag(1, 1'b0);
   endtask
   task automatic testOutput();
      sw(hmc_pkg::SEL_OUTPUT, 8'h3C);
      waitFlag(0, 1'b1);
      rd(hmc_pkg::SEL_OUTPUT, 8'hFF, 8'h3C);
      hmc_host_inst.hostRead(1'b1, rv, ok);
      chk(rv, 8'h01);
      hmc_host_inst.hostRead(1'b0, rv, ok);
      chk(rv, 8'h3C);
      waitFlag(0, 1'b0);
      chk({7'h00, hostDataOe_b}, 8'h01);
      hmc_host_inst.hostWrite(1'b0, 8'hC3);
      waitFlag(1, 1'b1);
      rd(hmc_pkg::SEL_OUTPUT, 8'hFF, 8'h3C);
      rd(hmc_pkg::SEL_INPUT, 8'hFF, 8'hC3);
      waitFlag(1, 1'b0);
   endtask
   task automatic testAlt();
      useAlt = 1'b1;
      hmc_host_inst.hostWrite(1'b1, 8'h66);
      rd(hmc_pkg::SEL_STATUS, 8'h02, 8'h00);
      sw(hmc_pkg::SEL_SHARED_CTRL, 8'h08);
      hmc_host_inst.hostWrite(1'b1, 8'h77);
      waitFlag(1, 1'b1);
      rd(hmc_pkg::SEL_INPUT, 8'hFF, 8'h77);
      waitFlag(1, 1'b0);
      useAlt = 1'b0;
      sw(hmc_pkg::SEL_SHARED_CTRL, 8'h00);
   endtask
   // Slave stalls while the host overruns the queue by one word
   task automatic testQueue();
      for (int i = 0; i < 18; i++) begin
         hmc_host_inst.hostWrite(1'b0, 8'(8'h10 + i));
      end
      chk({7'h00, hostQueueReady}, 8'h00);
      for (int i = 0; i < 17; i++) begin
         waitFlag(1, 1'b1);
         rd(hmc_pkg::SEL_INPUT, 8'hFF, 8'(8'h10 + i));
      end
      repeat (20) tick();
      rd(hmc_pkg::SEL_STATUS, 8'h02, 8'h00);
      chk({7'h00, hostQueueReady}, 8'h01);
   endtask
   task automatic testStandby();
      sw(hmc_pkg::SEL_STATUS, 8'hFF);
      rd(hmc_pkg::SEL_STATUS, 8'hFF, 8'hF4);
      sw(hmc_pkg::SEL_SHARED_CTRL, 8'h08);
      hwStandby_b = 1'b0;
      repeat (2) tick();
      hwStandby_b = 1'b1;
      rd(hmc_pkg::SEL_STATUS, 8'hFF, 8'h00);
      rd(hmc_pkg::SEL_SHARED_CTRL, 8'hFF, 8'h00);
      rd(hmc_pkg::SEL_PORT_CTRL, 8'hFF, 8'hF8);
      rd(hmc_pkg::SEL_SYS_CTRL, 8'hFF, 8'h00);
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      testReset();
      testWrite();
      testOutput();
      testAlt();
      testQueue();
      testStandby();
      stop_test();
   end
endmodule // tb_hmc_channel_two
